// ### src/fbcrb_params.svh
// Constants of the flash-backed control register bank.
// Assumes a 250 MHz core clock and a 6-bit byte address space.
`ifndef FBCRB_PARAMS_SVH
`define FBCRB_PARAMS_SVH
`define FBCRB_AW 6
`define FBCRB_NV_COUNT 10
`define FBCRB_CLK_MHZ 250
`define FBCRB_FLASH_UPD_MS 50
`define FBCRB_CAPT_COPY_MS 120
`define FBCRB_NULL_SAMPLES 64
`define FBCRB_NULL_SHIFT 6
// Byte addresses, low byte of each word
`define FBCRB_A_WEAR 6'h00
`define FBCRB_A_XNULL 6'h10
`define FBCRB_A_YNULL 6'h12
`define FBCRB_A_XSCALE 6'h14
`define FBCRB_A_YSCALE 6'h16
`define FBCRB_A_CAPT1 6'h1c
`define FBCRB_A_CAPT2 6'h1e
`define FBCRB_A_ALM1 6'h20
`define FBCRB_A_ALM2 6'h22
`define FBCRB_A_ALMCTL 6'h28
`define FBCRB_A_CPTR 6'h2a
`define FBCRB_A_DAC 6'h30
`define FBCRB_A_GPIO 6'h32
`define FBCRB_A_MISC 6'h34
`define FBCRB_A_SMPL 6'h36
`define FBCRB_A_CCFG 6'h38
`define FBCRB_A_SLEEP 6'h3a
`define FBCRB_A_STATUS 6'h3c
`define FBCRB_A_CMD 6'h3e
// Slots of the nonvolatile registers and their flash copies
`define FBCRB_NV_XNULL 4'h0
`define FBCRB_NV_YNULL 4'h1
`define FBCRB_NV_XSCALE 4'h2
`define FBCRB_NV_YSCALE 4'h3
`define FBCRB_NV_ALM1 4'h4
`define FBCRB_NV_ALM2 4'h5
`define FBCRB_NV_ALMCTL 4'h6
`define FBCRB_NV_MISC 4'h7
`define FBCRB_NV_SMPL 4'h8
`define FBCRB_NV_CCFG 4'h9
// Command bits
`define FBCRB_C_NULL 0
`define FBCRB_C_FACTORY 1
`define FBCRB_C_DAC 2
`define FBCRB_C_FLASH 3
`define FBCRB_C_CLRSTAT 4
`define FBCRB_C_CLRPEAK 5
`define FBCRB_C_CAPTCOPY 6
`define FBCRB_C_SWRST 7
`define FBCRB_C_CLRBUF 8
`define FBCRB_C_CLRCFL 9
`define FBCRB_C_CPTRRST 10
// Field positions and reset values
`define FBCRB_STAT_FLERR 2
`define FBCRB_MISC_SELFTEST 8
`define FBCRB_RST_NULL 16'h0000
`define FBCRB_RST_SCALE 16'h0800
`define FBCRB_RST_SMPL 16'h0001
`define FBCRB_RST_ZERO 16'h0000
`define FBCRB_CPTR_INIT 16'h0001
`endif

// ### src/fbcrb_pkg.sv
// Types of the flash-backed control register bank.
// Needs fbcrb_params.svh on the include path.
`include "fbcrb_params.svh"
package fbcrb_pkg;
  typedef enum logic [2:0] {
    FBCRB_BOOT = 3'b000,
    FBCRB_IDLE = 3'b001,
    FBCRB_FLASH = 3'b010,
    FBCRB_CAPT = 3'b011,
    FBCRB_NULL = 3'b100
  } fbcrb_fsm_t;
  typedef struct packed {
    fbcrb_fsm_t fsm;
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] din_sync;
    logic [1:0] sup_sync;
    logic [3:0] bitcnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] rd_data;
    logic dout;
    logic oe_n;
    logic [`FBCRB_NV_COUNT-1:0][15:0] nv;
    logic [`FBCRB_NV_COUNT-1:0][15:0] flash;
    logic [15:0] wear;
    logic [15:0] capture_address_pointer;
    logic [15:0] aux_dac;
    logic [15:0] gpio;
    logic [7:0] sleep;
    logic flash_err;
    logic [11:0] dac_out;
    logic [24:0] cnt;
    logic [6:0] ncnt;
    logic [19:0] accx;
    logic [19:0] accy;
    logic sleep_start;
    logic clear_peaks;
    logic capt_buf_clear;
    logic capt_flash_clear;
    logic cpu_restart;
    logic capt_busy;
  } fbcrb_state_t;
endpackage

// ### src/fbcrb_top.sv
// Control register bank with flash shadow, reached over a 4-wire serial port.
// Assumes serial pins are asynchronous to i_clock; samples come from same-clock logic.
//
// How it works
// - Working registers are volatile and load from flash at every start-up.
// - Each nonvolatile register has its flash slot; only a store updates it.
// - Read-only flash write counter sits at bytes 0x00 and 0x01.
// - Command register at 0x3E/0x3F is write-only; ones launch, zeros do nothing.
// - Flash update copies all nonvolatile registers, taking about 50 ms.
// - Status flash error bit shows zero on success, one on failure.
// - Reading the error bit clears it; flash update commands are ignored while it is set.
// - Software reset restarts the processor, reloads nonvolatile registers from flash and resets the others.
// - DAC latch command moves the DAC register to the output latch.
// - Autonull averages 64 samples per axis and stores the negated mean.
// - Factory restore returns offset null and scale registers to defaults.
// - Capture pointer reset command loads 0x0001.
// - Separate commands erase the capture buffer and its flash copy.
// - Capture flash copy stores the buffer, taking about 120 ms.
// - Misc control bit 8 starts self-test and clears itself when done.
// - Sleep counter at byte 0x3A is write-only, volatile, sets power-down length; writes to 0x3B are ignored.
// - Command bits 0 to 10 map to the eleven global functions.
// - Write frame: one, zero, 6-bit address, 8 data bits; one byte each.
// - Read frame: two zeros, address, don't care; data shifts out next frame.
`timescale 1ns/1ns
`include "fbcrb_params.svh"

module fbcrb_top #(
  parameter int FLASH_UPD_CYCLES = `FBCRB_FLASH_UPD_MS * 1000 * `FBCRB_CLK_MHZ,
  parameter int CAPT_COPY_CYCLES = `FBCRB_CAPT_COPY_MS * 1000 * `FBCRB_CLK_MHZ
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_din,
  output logic o_spi_dout,
  output logic o_spi_dout_oe_n,
  input wire logic i_supply_ok,
  input wire logic i_sample_valid,
  input wire logic [13:0] i_x_sample,
  input wire logic [13:0] i_y_sample,
  input wire logic [15:0] i_capture_one,
  input wire logic [15:0] i_capture_two,
  input wire logic i_selftest_done,
  output logic [11:0] o_dac_level,
  output logic [15:0] o_x_offset_null,
  output logic [15:0] o_y_offset_null,
  output logic [15:0] o_x_scale_factor,
  output logic [15:0] o_y_scale_factor,
  output logic [15:0] o_capture_address_pointer,
  output logic [15:0] o_sample_period_control,
  output logic o_selftest_run,
  output logic o_sleep_start,
  output logic [7:0] o_sleep_periods,
  output logic o_clear_peaks,
  output logic o_capture_buffer_clear,
  output logic o_capture_flash_clear,
  output logic o_capture_copy_busy,
  output logic o_cpu_restart
);

  fbcrb_pkg::fbcrb_state_t q;
  fbcrb_pkg::fbcrb_state_t d;

  // Word address of a byte address
  function automatic logic [`FBCRB_AW-1:0] word_addr(input logic [`FBCRB_AW-1:0] a);
    return {a[5:1], 1'b0};
  endfunction

  // Shifts a pin into a three-stage synchroniser
  function automatic logic [2:0] sync3(input logic [2:0] s, input logic pin);
    return {s[1:0], pin};
  endfunction

  // Rising edge seen between the last two synchroniser stages
  function automatic logic rose3(input logic [2:0] s);
    return ~s[2] & s[1];
  endfunction

  // Falling edge seen between the last two synchroniser stages
  function automatic logic fell3(input logic [2:0] s);
    return s[2] & ~s[1];
  endfunction

  // Next value of the operation timer
  function automatic logic [24:0] count_up(input logic [24:0] c);
    return c + 25'h000_0001;
  endfunction

  // Maps a word address to a nonvolatile slot
  function automatic logic [4:0] nv_slot(input logic [`FBCRB_AW-1:0] a);
    logic [4:0] r;
    r = 5'h10;
    case (word_addr(a))
      `FBCRB_A_XNULL: r = {1'b0, `FBCRB_NV_XNULL};
      `FBCRB_A_YNULL: r = {1'b0, `FBCRB_NV_YNULL};
      `FBCRB_A_XSCALE: r = {1'b0, `FBCRB_NV_XSCALE};
      `FBCRB_A_YSCALE: r = {1'b0, `FBCRB_NV_YSCALE};
      `FBCRB_A_ALM1: r = {1'b0, `FBCRB_NV_ALM1};
      `FBCRB_A_ALM2: r = {1'b0, `FBCRB_NV_ALM2};
      `FBCRB_A_ALMCTL: r = {1'b0, `FBCRB_NV_ALMCTL};
      `FBCRB_A_MISC: r = {1'b0, `FBCRB_NV_MISC};
      `FBCRB_A_SMPL: r = {1'b0, `FBCRB_NV_SMPL};
      `FBCRB_A_CCFG: r = {1'b0, `FBCRB_NV_CCFG};
      default: r = 5'h10;
    endcase
    return r;
  endfunction

  // Replaces one byte of a word
  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] b);
    return hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  // Sign-extends a 14-bit sample for the accumulators
  function automatic logic [19:0] sext20(input logic [13:0] s);
    return {{6{s[13]}}, s};
  endfunction

  // Negated mean of 64 samples, from the final sum
  function automatic logic [15:0] neg_mean(input logic [19:0] sum);
    logic [15:0] m;
    m = {{2{sum[19]}}, sum[19:`FBCRB_NULL_SHIFT]};
    return 16'h0000 - m;
  endfunction

  // Factory contents of the flash copies
  function automatic logic [`FBCRB_NV_COUNT-1:0][15:0] flash_defaults();
    logic [`FBCRB_NV_COUNT-1:0][15:0] f;
    f = '0;
    f[`FBCRB_NV_XNULL] = `FBCRB_RST_NULL;
    f[`FBCRB_NV_YNULL] = `FBCRB_RST_NULL;
    f[`FBCRB_NV_XSCALE] = `FBCRB_RST_SCALE;
    f[`FBCRB_NV_YSCALE] = `FBCRB_RST_SCALE;
    f[`FBCRB_NV_SMPL] = `FBCRB_RST_SMPL;
    return f;
  endfunction

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic [15:0] frame;
  logic [`FBCRB_AW-1:0] faddr;
  logic [4:0] slot;
  logic [15:0] cmd;
  logic busy;
  logic err_set;
  logic [19:0] sumx;
  logic [19:0] sumy;

  always_comb begin
    d = q;
    d.sleep_start = 1'b0;
    d.clear_peaks = 1'b0;
    d.capt_buf_clear = 1'b0;
    d.capt_flash_clear = 1'b0;
    d.cpu_restart = 1'b0;
    err_set = 1'b0;
    cmd = 16'h0000;
    sumx = q.accx + sext20(i_x_sample);
    sumy = q.accy + sext20(i_y_sample);

    // Pin synchronisers; stage 0 feeds only stage 1
    d.cs_sync = sync3(q.cs_sync, i_spi_cs_n);
    d.sclk_sync = sync3(q.sclk_sync, i_spi_sclk);
    d.din_sync = {q.din_sync[0], i_spi_din};
    d.sup_sync = {q.sup_sync[0], i_supply_ok};
    cs_fall = fell3(q.cs_sync);
    cs_rise = rose3(q.cs_sync);
    sclk_rise = rose3(q.sclk_sync) & ~q.cs_sync[1];
    sclk_fall = fell3(q.sclk_sync) & ~q.cs_sync[1];
    frame = {q.rx[14:0], q.din_sync[1]};
    frame_done = sclk_rise && (q.bitcnt == 4'hf);
    faddr = frame[13:8];
    slot = nv_slot(faddr);

    // Serial shifter
    if (cs_fall) begin
      d.bitcnt = 4'h0;
      d.tx = q.rd_data;
      d.dout = q.rd_data[15];
      d.oe_n = 1'b0;
    end else if (cs_rise) begin
      d.bitcnt = 4'h0;
      d.oe_n = 1'b1;
    end else begin
      if (sclk_rise) begin
        d.rx = frame;
        d.bitcnt = q.bitcnt + 4'h1;
      end
      if (sclk_fall && q.bitcnt != 4'h0) begin
        d.tx = {q.tx[14:0], 1'b0};
        d.dout = q.tx[14];
      end
    end

    busy = (q.fsm != fbcrb_pkg::FBCRB_IDLE);

    // Frame decode
    if (frame_done && frame[15:14] == 2'b10) begin
      if (slot[4] == 1'b0) begin
        d.nv[slot[3:0]] = put_byte(q.nv[slot[3:0]], faddr[0], frame[7:0]);
      end
      case (word_addr(faddr))
        `FBCRB_A_CPTR: d.capture_address_pointer = put_byte(q.capture_address_pointer, faddr[0], frame[7:0]);
        `FBCRB_A_DAC: d.aux_dac = put_byte(q.aux_dac, faddr[0], frame[7:0]);
        `FBCRB_A_GPIO: d.gpio = put_byte(q.gpio, faddr[0], frame[7:0]);
        `FBCRB_A_SLEEP: begin
          if (!faddr[0]) begin
            d.sleep = frame[7:0];
            d.sleep_start = 1'b1;
          end
        end
        `FBCRB_A_CMD: cmd = faddr[0] ? {frame[7:0], 8'h00} : {8'h00, frame[7:0]};
        default: cmd = 16'h0000;
      endcase
    end else if (frame_done && frame[15:14] == 2'b00) begin
      case (word_addr(faddr))
        `FBCRB_A_WEAR: d.rd_data = q.wear;
        `FBCRB_A_CAPT1: d.rd_data = i_capture_one;
        `FBCRB_A_CAPT2: d.rd_data = i_capture_two;
        `FBCRB_A_CPTR: d.rd_data = q.capture_address_pointer;
        `FBCRB_A_DAC: d.rd_data = q.aux_dac;
        `FBCRB_A_GPIO: d.rd_data = q.gpio;
        `FBCRB_A_STATUS: begin
          d.rd_data = 16'h0000;
          d.rd_data[`FBCRB_STAT_FLERR] = q.flash_err;
          d.flash_err = 1'b0;
        end
        default: d.rd_data = (slot[4] == 1'b0) ? q.nv[slot[3:0]] : 16'h0000;
      endcase
    end

    // Self-test completion
    if (i_selftest_done) begin
      d.nv[`FBCRB_NV_MISC][`FBCRB_MISC_SELFTEST] = 1'b0;
    end

    // Global commands
    if (cmd[`FBCRB_C_DAC]) begin
      d.dac_out = q.aux_dac[11:0];
    end
    if (cmd[`FBCRB_C_FACTORY]) begin
      d.nv[`FBCRB_NV_XNULL] = `FBCRB_RST_NULL;
      d.nv[`FBCRB_NV_YNULL] = `FBCRB_RST_NULL;
      d.nv[`FBCRB_NV_XSCALE] = `FBCRB_RST_SCALE;
      d.nv[`FBCRB_NV_YSCALE] = `FBCRB_RST_SCALE;
    end
    if (cmd[`FBCRB_C_CLRSTAT]) begin
      d.flash_err = 1'b0;
    end
    d.clear_peaks = cmd[`FBCRB_C_CLRPEAK];
    d.capt_buf_clear = cmd[`FBCRB_C_CLRBUF];
    if (cmd[`FBCRB_C_CPTRRST]) begin
      d.capture_address_pointer = `FBCRB_CPTR_INIT;
    end
    if (!busy) begin
      if (cmd[`FBCRB_C_FLASH] && !q.flash_err) begin
        d.fsm = fbcrb_pkg::FBCRB_FLASH;
        d.cnt = 25'h000_0000;
      end else if (cmd[`FBCRB_C_CAPTCOPY]) begin
        d.fsm = fbcrb_pkg::FBCRB_CAPT;
        d.cnt = 25'h000_0000;
      end else if (cmd[`FBCRB_C_CLRCFL]) begin
        d.capt_flash_clear = 1'b1;
      end else if (cmd[`FBCRB_C_NULL]) begin
        d.fsm = fbcrb_pkg::FBCRB_NULL;
        d.ncnt = 7'h00;
        d.accx = 20'h0_0000;
        d.accy = 20'h0_0000;
      end
    end

    // Background operations
    case (q.fsm)
      fbcrb_pkg::FBCRB_BOOT: begin
        d.nv = q.flash;
        d.nv[`FBCRB_NV_MISC][`FBCRB_MISC_SELFTEST] = 1'b0;
        d.capture_address_pointer = `FBCRB_CPTR_INIT;
        d.aux_dac = `FBCRB_RST_ZERO;
        d.gpio = `FBCRB_RST_ZERO;
        d.sleep = 8'h00;
        d.dac_out = 12'h000;
        d.fsm = fbcrb_pkg::FBCRB_IDLE;
      end
      fbcrb_pkg::FBCRB_IDLE: begin
        d.cnt = 25'h000_0000;
      end
      fbcrb_pkg::FBCRB_FLASH: begin
        d.cnt = count_up(q.cnt);
        if (q.cnt == 25'(FLASH_UPD_CYCLES - 1)) begin
          d.fsm = fbcrb_pkg::FBCRB_IDLE;
          if (q.sup_sync[1]) begin
            d.flash = q.nv;
            d.wear = q.wear + 16'h0001;
          end else begin
            err_set = 1'b1;
          end
        end
      end
      fbcrb_pkg::FBCRB_CAPT: begin
        d.cnt = count_up(q.cnt);
        if (q.cnt == 25'(CAPT_COPY_CYCLES - 1)) begin
          d.fsm = fbcrb_pkg::FBCRB_IDLE;
        end
      end
      fbcrb_pkg::FBCRB_NULL: begin
        if (i_sample_valid) begin
          d.accx = sumx;
          d.accy = sumy;
          d.ncnt = q.ncnt + 7'h01;
          if (q.ncnt == 7'(`FBCRB_NULL_SAMPLES - 1)) begin
            d.nv[`FBCRB_NV_XNULL] = neg_mean(sumx);
            d.nv[`FBCRB_NV_YNULL] = neg_mean(sumy);
            d.fsm = fbcrb_pkg::FBCRB_IDLE;
          end
        end
      end
      default: d.fsm = fbcrb_pkg::FBCRB_BOOT;
    endcase

    // A failure in the same cycle as a status read stays set
    if (err_set) begin
      d.flash_err = 1'b1;
    end

    // Software reset forces the state machine back to boot, whatever operation is in flight
    if (cmd[`FBCRB_C_SWRST]) begin
      d.fsm = fbcrb_pkg::FBCRB_BOOT;
      d.cpu_restart = 1'b1;
    end

    // Power-on reset: flash holds its factory image
    if (i_srst) begin
      d = '0;
      d.fsm = fbcrb_pkg::FBCRB_BOOT;
      d.cs_sync = 3'b111;
      d.sclk_sync = 3'b111;
      d.oe_n = 1'b1;
      d.flash = flash_defaults();
      d.capture_address_pointer = `FBCRB_CPTR_INIT;
      d.nv = flash_defaults();
    end

    // Busy flag kept in a flop so the output is registered
    d.capt_busy = (d.fsm == fbcrb_pkg::FBCRB_CAPT);
  end

  always_ff @(posedge i_clock) begin
    q <= d;
  end

  assign o_spi_dout = q.dout;
  assign o_spi_dout_oe_n = q.oe_n;
  assign o_dac_level = q.dac_out;
  assign o_x_offset_null = q.nv[`FBCRB_NV_XNULL];
  assign o_y_offset_null = q.nv[`FBCRB_NV_YNULL];
  assign o_x_scale_factor = q.nv[`FBCRB_NV_XSCALE];
  assign o_y_scale_factor = q.nv[`FBCRB_NV_YSCALE];
  assign o_capture_address_pointer = q.capture_address_pointer;
  assign o_sample_period_control = q.nv[`FBCRB_NV_SMPL];
  assign o_selftest_run = q.nv[`FBCRB_NV_MISC][`FBCRB_MISC_SELFTEST];
  assign o_sleep_start = q.sleep_start;
  assign o_sleep_periods = q.sleep;
  assign o_clear_peaks = q.clear_peaks;
  assign o_capture_buffer_clear = q.capt_buf_clear;
  assign o_capture_flash_clear = q.capt_flash_clear;
  assign o_capture_copy_busy = q.capt_busy;
  assign o_cpu_restart = q.cpu_restart;

endmodule // fbcrb_top

// ### verif/fbcrb_chk.sv
// Assertion checker for the flash-backed control register bank.
// Assumes it is bound to fbcrb_top and sees only its ports.
`timescale 1ns/1ns
module fbcrb_chk #(
  parameter int CAPT_COPY_CYCLES = 30
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_spi_cs_n,
  input wire logic i_selftest_done,
  input wire logic o_spi_dout_oe_n,
  input wire logic [11:0] o_dac_level,
  input wire logic [15:0] o_x_scale_factor,
  input wire logic [15:0] o_sample_period_control,
  input wire logic [15:0] o_capture_address_pointer,
  input wire logic o_selftest_run,
  input wire logic o_sleep_start,
  input wire logic [7:0] o_sleep_periods,
  input wire logic o_clear_peaks,
  input wire logic o_capture_buffer_clear,
  input wire logic o_capture_flash_clear,
  input wire logic o_capture_copy_busy,
  input wire logic o_cpu_restart
);
  logic [31:0] busy_q;
  logic [31:0] busy_d;
  always_comb begin
    busy_d = o_capture_copy_busy ? busy_q + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      busy_q <= 32'h0000_0000;
    end else begin
      busy_q <= busy_d;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence cs_idle_s;
    i_spi_cs_n [*8];
  endsequence
  sequence defaults_s;
    ##[0:4] (o_dac_level == 12'h000 && o_capture_address_pointer == 16'h0001);
  endsequence
  reset_values_a: assert property (disable iff (1'b0) i_srst |=>
    o_dac_level == 12'h000 && o_x_scale_factor == 16'h0800 && o_spi_dout_oe_n
    && o_sample_period_control == 16'h0001) else $error("Reset values wrong");
  idle_release_a: assert property (cs_idle_s |-> o_spi_dout_oe_n)
    else $error("Data out driven while deselected");
  dac_hold_a: assert property (cs_idle_s |=> $stable(o_dac_level)
    && $stable(o_x_scale_factor) && $stable(o_sample_period_control))
    else $error("Output changed without a frame");
  peaks_pulse_a: assert property (o_clear_peaks |=> !o_clear_peaks)
    else $error("Clear peaks pulse too long");
  clear_pulse_a: assert property ((o_capture_buffer_clear || o_capture_flash_clear)
    |=> !(o_capture_buffer_clear || o_capture_flash_clear)) else $error("Clear pulse too long");
  sleep_pulse_a: assert property (o_sleep_start |=> !o_sleep_start
    && $stable(o_sleep_periods)) else $error("Sleep pulse wrong");
  selftest_end_a: assert property (o_selftest_run && i_selftest_done
    |=> !o_selftest_run) else $error("Self-test bit not cleared");
  restart_dflt_a: assert property (o_cpu_restart |-> defaults_s)
    else $error("Restart did not restore defaults");
  copy_short_a: assert property ($fell(o_capture_copy_busy)
    |-> busy_q >= 32'(CAPT_COPY_CYCLES - 2)) else $error("Capture copy ended early");
  copy_long_a: assert property (busy_q <= 32'(CAPT_COPY_CYCLES + 2))
    else $error("Capture copy ran too long");
endmodule // fbcrb_chk
bind fbcrb_top fbcrb_chk #(.CAPT_COPY_CYCLES(CAPT_COPY_CYCLES)) chk (.*);

// ### verif/fbcrb_host.sv
// Serial host model: 16-bit frames, clock idle high, still between frames.
// Assumes the device shifts data out after falling clock edges.
`timescale 1ns/1ns
module fbcrb_host (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din,
  input wire logic i_dout,
  input wire logic i_dout_oe_n
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end
  // One full frame, most significant bit first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #2;
    o_cs_n = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din = tx[i];
      #24;
      o_sclk = 1'b1;
      rx[i] = i_dout_oe_n ? ~i_dout : i_dout;
      #24;
    end
    o_cs_n = 1'b1;
    o_din = ~o_din;
    #48;
  endtask
endmodule // fbcrb_host

// ### verif/testbench.sv
// Self-checking bench for the flash-backed control register bank.
// Assumes fbcrb_top, fbcrb_host and fbcrb_chk are compiled first.
`timescale 1ns/1ns
module testbench;
  logic i_clock, i_srst, i_spi_cs_n, i_spi_sclk, i_spi_din, i_supply_ok, i_sample_valid;
  logic i_selftest_done, o_spi_dout, o_spi_dout_oe_n, o_selftest_run, o_sleep_start;
  logic o_clear_peaks, o_capture_buffer_clear, o_capture_flash_clear, o_capture_copy_busy;
  logic o_cpu_restart;
  logic [13:0] i_x_sample, i_y_sample;
  logic [15:0] i_capture_one, i_capture_two, o_x_offset_null, o_y_offset_null;
  logic [15:0] o_x_scale_factor, o_y_scale_factor, o_capture_address_pointer;
  logic [15:0] o_sample_period_control, v;
  logic [11:0] o_dac_level;
  logic [7:0] o_sleep_periods;
  logic [5:0] seen;
  logic seen_clr;
  logic [31:0] rnd;
  logic [5:0] cmd_a [7] = '{6'h3e, 6'h3f, 6'h3f, 6'h3e, 6'h3e, 6'h3a, 6'h3e};
  logic [7:0] cmd_d [7] = '{8'h20, 8'h01, 8'h02, 8'h40, 8'h10, 8'h07, 8'h80};
  logic [5:0] cmd_m [7] = '{6'h10, 6'h08, 6'h04, 6'h01, 6'h00, 6'h02, 6'h20};
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  fbcrb_top #(.FLASH_UPD_CYCLES(20), .CAPT_COPY_CYCLES(30)) uut (.*);
  fbcrb_host host (.o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk), .o_din(i_spi_din),
    .i_dout(o_spi_dout), .i_dout_oe_n(o_spi_dout_oe_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] null_of(input logic [13:0] x);
    return -{{2{x[13]}}, x};
  endfunction
  task automatic check(input string name, input logic [15:0] seen_v, input logic [15:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen_v);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({2'b10, a, d}, r);
  endtask
  task automatic rchk(input logic [5:0] a, input string name, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer({2'b00, a, 8'h00}, r);
    host.xfer(16'h0000, r);
    check(name, r, exp);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // Pulse monitor and run-time limit
  always @(posedge i_clock) begin
    seen <= seen_clr ? 6'h00 : seen | {o_cpu_restart, o_clear_peaks, o_capture_buffer_clear,
      o_capture_flash_clear, o_sleep_start, o_capture_copy_busy};
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      results();
    end
  end
  initial begin
    i_srst = 1'b1;
    i_supply_ok = 1'b1;
    i_sample_valid = 1'b0;
    i_selftest_done = 1'b0;
    i_x_sample = '0;
    i_y_sample = '0;
    i_capture_one = '0;
    i_capture_two = '0;
    seen_clr = 1'b1;
    rnd = 32'h8088;
    tick(2);
    i_srst = 1'b0;
    tick(4);
    check("period_out", o_sample_period_control, 16'h0001);
    rchk(6'h14, "x_scale", 16'h0800);
    wr(6'h00, 8'hff);
    rchk(6'h01, "wear_ro", 16'h0000);
    rchk(6'h3e, "command_wo", 16'h0000);
    rchk(6'h3a, "sleep_wo", 16'h0000);
    rnd = lfsr(rnd);
    i_capture_one = rnd[15:0];
    i_capture_two = rnd[31:16];
    rchk(6'h1d, "capture_one", rnd[15:0]);
    rchk(6'h1e, "capture_two", rnd[31:16]);
    wr(6'h30, rnd[7:0]);
    wr(6'h31, rnd[15:8]);
    check("dac_before", o_dac_level, 12'h000);
    wr(6'h3e, 8'h04);
    check("dac_latched", o_dac_level, rnd[11:0]);
    v = {4'h0, rnd[27:16]};
    wr(6'h10, v[7:0]);
    wr(6'h11, v[15:8]);
    rchk(6'h10, "x_null", v);
    wr(6'h3e, 8'h08);
    tick(30);
    rchk(6'h00, "wear_one", 16'h0001);
    rchk(6'h3c, "status_ok", 16'h0000);
    wr(6'h10, ~v[7:0]);
    wr(6'h3e, 8'h80);
    tick(8);
    rchk(6'h10, "x_null_reload", v);
    check("dac_restart", o_dac_level, 12'h000);
    i_supply_ok = 1'b0;
    wr(6'h3e, 8'h08);
    tick(30);
    i_supply_ok = 1'b1;
    wr(6'h3e, 8'h08);
    tick(30);
    rchk(6'h3c, "status_err", 16'h0004);
    rchk(6'h3c, "status_clr", 16'h0000);
    rchk(6'h00, "wear_kept", 16'h0001);
    wr(6'h16, rnd[7:0]);
    wr(6'h3e, 8'h02);
    check("y_scale_dflt", o_y_scale_factor, 16'h0800);
    check("x_null_dflt", o_x_offset_null, 16'h0000);
    wr(6'h2a, rnd[15:8] | 8'h02);
    check("pointer_set", o_capture_address_pointer[7:0], rnd[15:8] | 8'h02);
    wr(6'h3f, 8'h04);
    check("pointer_init", o_capture_address_pointer, 16'h0001);
    rnd = lfsr(rnd);
    i_x_sample = rnd[13:0];
    i_y_sample = 14'h3ffe;
    wr(6'h3e, 8'h01);
    repeat (80) begin
      i_sample_valid = 1'b1;
      tick(1);
      i_sample_valid = 1'b0;
      tick(1);
    end
    check("x_autonull", o_x_offset_null, null_of(rnd[13:0]));
    check("y_autonull", o_y_offset_null, 16'h0002);
    wr(6'h35, 8'h01);
    check("selftest_on", o_selftest_run, 1'b1);
    i_selftest_done = 1'b1;
    tick(1);
    i_selftest_done = 1'b0;
    tick(2);
    check("selftest_off", o_selftest_run, 1'b0);
    for (int k = 0; k < 7; k++) begin
      seen_clr = 1'b1;
      tick(1);
      seen_clr = 1'b0;
      wr(cmd_a[k], cmd_d[k]);
      tick(40);
      check("pulses", {10'h000, seen}, {10'h000, cmd_m[k]});
      if (k == 5) begin
        check("sleep_len", o_sleep_periods, 8'h07);
      end
    end
    check("sleep_cleared", o_sleep_periods, 8'h00);
    results();
  end
endmodule // testbench
